//--- hdl/flash_ecc_map.vh
/*
  register offsets, field positions, reset values and timing counts
  of the flash page-mode and NAND ECC register block.
  assumes 32-bit APB, one register per aligned word.
*/
`ifndef FLASH_ECC_MAP_VH
`define FLASH_ECC_MAP_VH

// register byte offsets
`define OFS_PAGE_CTRL     12'h000
`define OFS_EVEN_PAR      12'h004
`define OFS_ODD_PAR       12'h008
`define OFS_QUAD_LOAD     12'h00c
`define OFS_QUAD_RES1     12'h010
`define OFS_NAND_CTRL     12'h014
`define OFS_PAR_SEL       12'h018
`define OFS_STATUS        12'h01c

// page control fields
`define TOP_WAIT_HI       15
`define TOP_WAIT_LO       10
`define TOP_LEN_BIT       9
`define TOP_ON_BIT        8
`define THIRD_WAIT_HI     7
`define THIRD_WAIT_LO     2
`define THIRD_LEN_BIT     1
`define THIRD_ON_BIT      0
`define PAGE_CTRL_RESET   16'hfcfc

// nand control fields
`define QUAD_GO_BIT       12
`define PAR_GO_LO         8
`define QUAD_SEL_HI       5
`define QUAD_SEL_LO       4
`define WIDE16_BIT        0

// field widths and counts
`define PAR_W             12
`define QUAD_W            10
`define PAGE_WORDS_SHORT  4'h4
`define PAGE_WORDS_LONG   4'h8

`endif

//--- hdl/flash_ecc_page_mode_regs.v
/*
  APB register block for upper chip select page-mode reads and NAND
  1-bit parity and 4-bit ECC load/result.
  assumes an APB master, 32-bit data, NAND data words on nand_* ports,
  and the 4-bit ECC engine outside supplying its first value.
*/
`include "flash_ecc_map.vh"

// Overview of operation
// - top select samples after wait plus one
// - page length bit picks 4 or 8 words
// - page enable bit turns page reads on
// - low byte holds third select settings
// - even and odd parity, upper bits zero
// - 8-bit: three column, rest row parities
// - 16-bit: four column, rest row parities
// - weight 2^k stored at bit k
// - software loads 10-bit values for syndrome
// - first ECC or syndrome value is shown
// - parity go set by 1, cleared on read
// - 2-bit field selects 4-bit ECC select
// - quad go cleared only by a read of the first result register
module flash_ecc_page_mode_regs
#(
  parameter NSEL = 4
)
(
  // apb
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // nand data path
  input  wire        nand_valid,
  input  wire [1:0]  nand_select,
  input  wire [15:0] nand_data,
  input  wire [10:0] nand_word_index,
  input  wire [9:0]  quad_ecc_result_first,
  // nor page reads
  input  wire        chip_select_three_pin,
  input  wire        chip_select_four_pin,
  output reg         third_sample_q,
  output reg         top_sample_q,
  // quad ecc engine
  output reg  [9:0]  quad_ecc_load_value,
  output reg         quad_ecc_load_strobe_q,
  output reg         quad_ecc_go,
  output reg  [1:0]  quad_ecc_select_choice
);

  ////////////////////////////////////////////////////////////////////
  reg  [15:0]         page_ctrl_q;
  reg  [NSEL-1:0]     parity_accumulate_go;
  reg                 wide16_q;
  reg  [1:0]          par_view_q;
  reg  [9:0]          res1_q;
  reg                 cs3_q;
  reg                 cs4_q;
  wire                wr;
  wire                rd;
  wire                third_smp;
  wire                top_smp;
  wire                third_busy;
  wire                top_busy;
  wire [5:0]          top_select_page_wait;
  wire [5:0]          third_select_page_wait;
  wire                top_select_page_length;
  wire                third_select_page_length;
  wire                top_select_page_read_on;
  wire                third_select_page_read_on;
  wire [`PAR_W-1:0]   even_par [0:NSEL-1];
  wire [`PAR_W-1:0]   odd_par  [0:NSEL-1];
  wire                par_rd;
  // address decode and read mux
  wire                setup;
  wire                hit_page;
  wire                hit_even;
  wire                hit_odd;
  wire                hit_load;
  wire                hit_res1;
  wire                hit_ctrl;
  wire                hit_view;
  wire                hit_stat;
  wire                wr_ctrl;
  wire [NSEL-1:0]     par_start;
  reg  [31:0]         rdata_d;
  reg                 rerr_d;

  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign setup = psel && !penable;

  // address decode, one hit per register word
  assign hit_page = (paddr == `OFS_PAGE_CTRL);
  assign hit_even = (paddr == `OFS_EVEN_PAR);
  assign hit_odd  = (paddr == `OFS_ODD_PAR);
  assign hit_load = (paddr == `OFS_QUAD_LOAD);
  assign hit_res1 = (paddr == `OFS_QUAD_RES1);
  assign hit_ctrl = (paddr == `OFS_NAND_CTRL);
  assign hit_view = (paddr == `OFS_PAR_SEL);
  assign hit_stat = (paddr == `OFS_STATUS);
  assign wr_ctrl  = wr && hit_ctrl;

  // top select wait in upper field
  assign top_select_page_wait      = page_ctrl_q[`TOP_WAIT_HI:`TOP_WAIT_LO];
  assign top_select_page_length    = page_ctrl_q[`TOP_LEN_BIT];
  assign top_select_page_read_on   = page_ctrl_q[`TOP_ON_BIT];
  // third select mirrors layout in low byte
  assign third_select_page_wait    = page_ctrl_q[`THIRD_WAIT_HI:`THIRD_WAIT_LO];
  assign third_select_page_length  = page_ctrl_q[`THIRD_LEN_BIT];
  assign third_select_page_read_on = page_ctrl_q[`THIRD_ON_BIT];

  // parity register read clears its go bit
  assign par_rd = rd && (hit_even || hit_odd);

  ////////////////////////////////////////////////////////////////////
  page_read_timer u_third
  (
    .pclk         (pclk),
    .presetn      (presetn),
    .page_wait    (third_select_page_wait),
    .page_length  (third_select_page_length),
    .page_read_on (third_select_page_read_on),
    .read_start   (chip_select_three_pin && !cs3_q),
    .sample_q     (third_smp),
    .busy_q       (third_busy)
  );

  page_read_timer u_top
  (
    .pclk         (pclk),
    .presetn      (presetn),
    .page_wait    (top_select_page_wait),
    .page_length  (top_select_page_length),
    .page_read_on (top_select_page_read_on),
    .read_start   (chip_select_four_pin && !cs4_q),
    .sample_q     (top_smp),
    .busy_q       (top_busy)
  );

  // one parity pair per chip select
  genvar g;
  generate
    for (g = 0; g < NSEL; g = g + 1)
    begin : g_par
      // go rising from 0 clears the pair first
      assign par_start[g] = wr_ctrl && pwdata[`PAR_GO_LO+g] && !parity_accumulate_go[g];

      parity_accum u_acc
      (
        .pclk       (pclk),
        .presetn    (presetn),
        .clear      (par_start[g]),
        .enable     (parity_accumulate_go[g]),
        .wide16     (wide16_q),
        .data_valid (nand_valid && (nand_select == g)),
        .data       (nand_data),
        .word_index (nand_word_index),
        .even_q     (even_par[g]),
        .odd_q      (odd_par[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      page_ctrl_q            <= `PAGE_CTRL_RESET;
      parity_accumulate_go   <= {NSEL{1'b0}};
      wide16_q               <= 1'b0;
      par_view_q             <= 2'h0;
      quad_ecc_load_value    <= 10'h000;
      quad_ecc_load_strobe_q <= 1'b0;
      quad_ecc_go            <= 1'b0;
      quad_ecc_select_choice <= 2'h0;
    end
    else
    begin
      quad_ecc_load_strobe_q <= 1'b0;
      // read clears go of the viewed select
      if (par_rd)
        parity_accumulate_go[par_view_q] <= 1'b0;
      if (rd && (paddr == `OFS_QUAD_RES1))
        quad_ecc_go <= 1'b0;
      if (wr)
      begin
        case (paddr)
          // zero wait not guarded, software keeps it nonzero
          `OFS_PAGE_CTRL: page_ctrl_q <= pwdata[15:0];
          // each load write feeds the syndrome engine
          `OFS_QUAD_LOAD:
          begin
            quad_ecc_load_value    <= pwdata[`QUAD_W-1:0];
            quad_ecc_load_strobe_q <= 1'b1;
          end
          `OFS_NAND_CTRL:
          begin
            // write 1 sets, write 0 no effect
            parity_accumulate_go <= parity_accumulate_go
                                    | pwdata[`PAR_GO_LO+NSEL-1:`PAR_GO_LO];
            if (pwdata[`QUAD_GO_BIT])
              quad_ecc_go <= 1'b1;
            // select code 0..3 maps to selects
            quad_ecc_select_choice <= pwdata[`QUAD_SEL_HI:`QUAD_SEL_LO];
            wide16_q <= pwdata[`WIDE16_BIT];
          end
          `OFS_PAR_SEL: par_view_q <= pwdata[1:0];
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // pin edge history and registered sample pulses
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cs3_q          <= 1'b0;
      cs4_q          <= 1'b0;
      third_sample_q <= 1'b0;
      top_sample_q   <= 1'b0;
    end
    else
    begin
      cs3_q          <= chip_select_three_pin;
      cs4_q          <= chip_select_four_pin;
      third_sample_q <= third_smp;
      top_sample_q   <= top_smp;
    end
  end

  // capture first value while engine runs
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      res1_q <= 10'h000;
    else if (quad_ecc_go)
      res1_q <= quad_ecc_result_first;
  end

  ////////////////////////////////////////////////////////////////////
  // read mux, looked up in the setup cycle
  always @*
  begin
    rdata_d = 32'h00000000;
    rerr_d  = 1'b0;
    if (hit_page)
      rdata_d = {16'h0000, page_ctrl_q};
    else if (hit_even)
      rdata_d = {20'h00000, even_par[par_view_q]};
    else if (hit_odd)
      rdata_d = {20'h00000, odd_par[par_view_q]};
    else if (hit_load)
      rdata_d = {22'h0, quad_ecc_load_value};
    else if (hit_res1)
      rdata_d = {22'h0, res1_q};
    else if (hit_ctrl)
      rdata_d = {19'h0, quad_ecc_go, parity_accumulate_go,
                 2'h0, quad_ecc_select_choice, 3'h0, wide16_q};
    else if (hit_view)
      rdata_d = {30'h0, par_view_q};
    else if (hit_stat)
      rdata_d = {30'h0, top_busy, third_busy};
    else
      rerr_d = 1'b1;
  end

  // answer in the access cycle, never a wait state
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      // pslverr and prdata pulse with pready only
      pready  <= setup;
      pslverr <= setup && rerr_d;
      prdata  <= setup ? rdata_d : 32'h00000000;
    end
  end

endmodule // flash_ecc_page_mode_regs

//--- hdl/page_read_timer.v
/*
  page-mode read timer for one chip select: counts wait+1 cycles per word
  and walks through a 4- or 8-word page.
  assumes wait is never zero and read_start is a one-cycle pulse.
*/
`include "flash_ecc_map.vh"

module page_read_timer
(
  // clock and reset
  input  wire       pclk,
  input  wire       presetn,
  // settings
  input  wire [5:0] page_wait,
  input  wire       page_length,
  input  wire       page_read_on,
  // control and result
  input  wire       read_start,
  output reg        sample_q,
  output reg        busy_q
);

  reg  [6:0] cnt_q;
  reg  [3:0] word_q;
  wire [3:0] words;

  assign words = page_length ? `PAGE_WORDS_LONG : `PAGE_WORDS_SHORT;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q    <= 7'h00;
      word_q   <= 4'h0;
      sample_q <= 1'b0;
      busy_q   <= 1'b0;
    end
    else
    begin
      sample_q <= 1'b0;
      // only runs when page mode is on
      if (!busy_q && read_start && page_read_on)
      begin
        busy_q <= 1'b1;
        cnt_q  <= 7'h00;
        word_q <= 4'h0;
      end
      else if (busy_q)
      begin
        // sample after wait plus one cycles
        if (cnt_q == {1'b0, page_wait})
        begin
          sample_q <= 1'b1;
          cnt_q    <= 7'h00;
          word_q   <= word_q + 4'h1;
          if (word_q == words - 4'h1)
            busy_q <= 1'b0;
        end
        else
          cnt_q <= cnt_q + 7'h01;
      end
    end
  end

endmodule // page_read_timer

//--- hdl/parity_accum.v
/*
  1-bit Hamming parity accumulator for one chip select: even and odd
  parity over byte offset and bit position of each NAND data word.
  assumes data_valid marks one accepted data word per cycle.
*/
`include "flash_ecc_map.vh"

module parity_accum
(
  // clock and reset
  input  wire                 pclk,
  input  wire                 presetn,
  // control
  input  wire                 clear,
  input  wire                 enable,
  input  wire                 wide16,
  // data
  input  wire                 data_valid,
  input  wire [15:0]          data,
  input  wire [10:0]          word_index,
  // result
  output reg  [`PAR_W-1:0]    even_q,
  output reg  [`PAR_W-1:0]    odd_q
);

  reg  [`PAR_W-1:0] even_d;
  reg  [`PAR_W-1:0] odd_d;
  reg  [15:0]       lane;
  reg  [11:0]       addr;
  reg               par;
  integer           i;
  integer           k;

  // 8-bit: 3 column bits, rows from weight 8
  // 16-bit: 4 column bits, rows from weight 16
  always @*
  begin
    even_d = even_q;
    odd_d  = odd_q;
    lane   = wide16 ? data : {8'h00, data[7:0]};
    addr   = 12'h000;
    par    = 1'b0;
    for (i = 0; i < 16; i = i + 1)
    begin
      if (wide16)
        addr = {word_index[7:0], i[3:0]};
      else
        addr = {word_index[8:0], i[2:0]};
      par = lane[i];
      // weight 2^k sits at bit k
      for (k = 0; k < `PAR_W; k = k + 1)
      begin
        if (addr[k])
          odd_d[k] = odd_d[k] ^ par;
        else
          even_d[k] = even_d[k] ^ par;
      end
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      even_q <= {`PAR_W{1'b0}};
      odd_q  <= {`PAR_W{1'b0}};
    end
    else if (clear)
    begin
      even_q <= {`PAR_W{1'b0}};
      odd_q  <= {`PAR_W{1'b0}};
    end
    else if (enable && data_valid)
    begin
      even_q <= even_d;
      odd_q  <= odd_d;
    end
  end

endmodule // parity_accum

//--- verification/flash_ecc_sva.sv
/* port checker of the flash page and ecc register block.
   assumes one pclk domain and async active-low presetn. */
`include "flash_ecc_map.vh"
module flash_ecc_sva
(
  // apb
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // outputs
  input wire logic        top_sample_q,
  input wire logic [9:0]  quad_ecc_load_value,
  input wire logic        quad_ecc_load_strobe_q,
  input wire logic        quad_ecc_go,
  input wire logic [1:0]  quad_ecc_select_choice
);
  timeunit 1ns;
  timeprecision 1ns;
  wire       wr   = psel && penable && pready && pwrite;
  wire       rd   = psel && penable && pready && !pwrite;
  wire [9:0] ldv  = pwdata[9:0];
  wire [1:0] seln = pwdata[5:4];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////
  property p_ans; psel && !penable |=> pready; endproperty
  a_ans: assert property (p_ans) else $error("no answer after setup");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("pready held");
  property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("bad error reply");
  property p_par;
    rd && (paddr == `OFS_EVEN_PAR || paddr == `OFS_ODD_PAR) |-> prdata[31:12] == 20'h0;
  endproperty
  a_par: assert property (p_par) else $error("parity upper bits set");
  property p_ld;
    wr && paddr == `OFS_QUAD_LOAD |=> quad_ecc_load_strobe_q && quad_ecc_load_value == $past(ldv);
  endproperty
  a_ld: assert property (p_ld) else $error("load value not passed");
  property p_sel; wr && paddr == `OFS_NAND_CTRL |=> quad_ecc_select_choice == $past(seln);
  endproperty
  a_sel: assert property (p_sel) else $error("select choice wrong");
  property p_qon; wr && paddr == `OFS_NAND_CTRL && pwdata[12] |=> quad_ecc_go; endproperty
  a_qon: assert property (p_qon) else $error("quad go not set");
  property p_qoff; rd && paddr == `OFS_QUAD_RES1 |=> !quad_ecc_go; endproperty
  a_qoff: assert property (p_qoff) else $error("quad go not cleared");
  property p_tick; top_sample_q |=> !top_sample_q; endproperty
  a_tick: assert property (p_tick) else $error("page tick too long");
endmodule // flash_ecc_sva

bind flash_ecc_page_mode_regs flash_ecc_sva u_sva (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .top_sample_q(top_sample_q),
  .quad_ecc_load_value(quad_ecc_load_value), .quad_ecc_load_strobe_q(quad_ecc_load_strobe_q),
  .quad_ecc_go(quad_ecc_go), .quad_ecc_select_choice(quad_ecc_select_choice));

//--- verification/flash_far_side.sv
/* far side model: nor chip-select pins and nand data words.
   driven by bench tasks, changes just after pclk edges. */
module flash_far_side
(
  // clock
  input  wire logic        pclk,
  // nand side
  output logic             nand_valid,
  output logic [1:0]       nand_select,
  output logic [15:0]      nand_data,
  output logic [10:0]      nand_word_index,
  output logic [9:0]       quad_ecc_result_first,
  // nor side
  output logic             chip_select_three_pin,
  output logic             chip_select_four_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    nand_valid = 0;
    nand_select = 0;
    nand_data = 0;
    nand_word_index = 0;
    quad_ecc_result_first = 0;
    chip_select_three_pin = 0;
    chip_select_four_pin = 0;
  end
  task word(input logic [1:0] s, input logic [15:0] d, input logic [10:0] i);
    @(posedge pclk);
    nand_valid <= 1'b1;
    nand_select <= s;
    nand_data <= d;
    nand_word_index <= i;
    @(posedge pclk);
    nand_valid <= 1'b0;
    // released bus never keeps the last word
    nand_data <= ~d;
  endtask
  task pin(input logic top, input logic lvl);
    @(posedge pclk);
    if (top)
      chip_select_four_pin <= lvl;
    else
      chip_select_three_pin <= lvl;
  endtask
  task result(input logic [9:0] v);
    @(posedge pclk);
    quad_ecc_result_first <= v;
  endtask
endmodule // flash_far_side

//--- verification/tb_top.sv
/* self-checking bench of the flash page and ecc register block.
   apb master tasks plus the far side model; expectations from integers. */
`include "flash_ecc_map.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0, ev, od;
  logic [31:0] pwdata = 0, prdata, r;
  logic        pready, pslverr, e, nv, c3, c4, s3, s4, ldst, qgo;
  logic [1:0]  ns, qsel;
  logic [15:0] nd, d16;
  logic [10:0] ni, ix;
  logic [9:0]  qres, qld;
  logic [7:0]  h;
  int          n_mismatch = 0, check_count = 0, seed = 30, i, j, k, a, w;
  always #25 pclk = ~pclk;
  flash_ecc_page_mode_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .nand_valid(nv), .nand_select(ns), .nand_data(nd),
    .nand_word_index(ni), .quad_ecc_result_first(qres), .chip_select_three_pin(c3),
    .chip_select_four_pin(c4), .third_sample_q(s3), .top_sample_q(s4),
    .quad_ecc_load_value(qld), .quad_ecc_load_strobe_q(ldst), .quad_ecc_go(qgo),
    .quad_ecc_select_choice(qsel));
  flash_far_side u_far (.pclk(pclk), .nand_valid(nv), .nand_select(ns), .nand_data(nd),
    .nand_word_index(ni), .quad_ecc_result_first(qres), .chip_select_three_pin(c3),
    .chip_select_four_pin(c4));
  ////////////////////////////////////////
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    if (pready !== 1'b1)
    begin
      n_mismatch++;
      tally_and_finish;
    end
  endtask
  ////////////////////////////////////////
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1;
    for (i = 0; i < 9; i++)
    begin
      apb(0, 12'(i * 4), 0);
      chk("reset_val", r, i == 0 ? 32'hfcfc : 32'h0);
      chk("slv_err", {31'h0, e}, {31'h0, i == 8});
    end
    apb(1, 12'h020, 32'hffff);
    apb(0, `OFS_PAGE_CTRL, 0);
    chk("unmapped_wr", r, 32'hfcfc);
    $display("test reset done");
    for (i = 0; i < 6; i++)
    begin
      w = (i == 0) ? 1 : 1 + ($random(seed) & 7);
      h = {6'(w), i[1], (i < 4)};
      apb(1, `OFS_PAGE_CTRL, {16'h0, h, h});
      apb(0, `OFS_PAGE_CTRL, 0);
      chk("page_ctrl", r, {16'h0, h, h});
      u_far.pin(i[0], 1);
      k = 0;
      for (j = 1; j < w * 9 + 12; j++)
      begin
        @(posedge pclk);
        #1;
        if ((i[0] ? s4 : s3) === 1'b1)
        begin
          chk("page_tick", j, w + 3 + k * (w + 1));
          k++;
        end
      end
      chk("page_words", k, i > 3 ? 0 : (i[1] ? 8 : 4));
      u_far.pin(i[0], 0);
    end
    $display("test page done");
    for (i = 0; i < 4; i++)
    begin
      apb(1, `OFS_PAR_SEL, i);
      apb(1, `OFS_NAND_CTRL, (1 << (8 + i)) | i[0]);
      ev = 0;
      od = 0;
      for (j = 0; j < 6; j++)
      begin
        d16 = 16'($random(seed));
        ix = 11'($random(seed)) & (i[0] ? 11'h07f : 11'h0ff);
        u_far.word(2'(i), d16, ix);
        u_far.word(2'(i ^ 1), ~d16, ix);
        for (k = 0; k < (i[0] ? 16 : 8); k++)
          if (d16[k])
          begin
            a = i[0] ? ix * 16 + k : ix * 8 + k;
            ev ^= ~a[11:0];
            od ^= a[11:0];
          end
      end
      apb(0, `OFS_EVEN_PAR, 0);
      chk("even_par", r, {20'h0, ev});
      apb(0, `OFS_ODD_PAR, 0);
      chk("odd_par", r, {20'h0, od});
      apb(0, `OFS_NAND_CTRL, 0);
      chk("par_go_clear", r, {31'h0, i[0]});
    end
    $display("test parity done");
    for (i = 0; i < 4; i++)
    begin
      a = $random(seed) & 32'h3ff;
      apb(1, `OFS_QUAD_LOAD, a);
      #1;
      chk("quad_load_strobe", {31'h0, ldst}, 1);
      apb(0, `OFS_QUAD_LOAD, 0);
      chk("quad_load", r, a);
      chk("quad_load_pin", {22'h0, qld}, a);
      u_far.result(10'(~a));
      apb(1, `OFS_NAND_CTRL, 32'h1000 | (i << 4));
      #1;
      chk("quad_go_pin", {31'h0, qgo}, 1);
      apb(0, `OFS_QUAD_RES1, 0);
      chk("quad_res", r, {22'h0, ~a[9:0]});
      chk("quad_sel", {30'h0, qsel}, i);
      apb(0, `OFS_NAND_CTRL, 0);
      chk("quad_go_clear", r, i << 4);
    end
    $display("test quad done");
    tally_and_finish;
  end
endmodule // tb_top
